// ===== core/serial_flags_pkg.sv
// constants, register map and carrier structs for the serial flag and pin-change block
// assumes a single 100 MHz clock and a plain register port with one-cycle read latency
package serial_flags_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PIN_N  = 6;

    // register offsets
    localparam logic [3:0] OFF_SERIAL_FLAGS = 4'h0;
    localparam logic [3:0] OFF_RISE_EN      = 4'h1;
    localparam logic [3:0] OFF_FALL_EN      = 4'h2;
    localparam logic [3:0] OFF_PIN_FLAGS    = 4'h3;
    localparam logic [3:0] OFF_IRQ_STATUS   = 4'h4;
    localparam logic [3:0] OFF_IRQ_ENABLE   = 4'h5;
    localparam logic [3:0] OFF_IRQ_CLEAR    = 4'h6;
    localparam logic [3:0] OFF_TX_STATUS    = 4'h7;

    // serial flag bit positions
    localparam int BIT_U2_RX   = 7;
    localparam int BIT_U2_TX   = 6;
    localparam int BIT_U1_RX   = 5;
    localparam int BIT_U1_TX   = 4;
    localparam int BIT_S2_COLL = 3;
    localparam int BIT_S2_DONE = 2;
    localparam int BIT_S1_COLL = 1;
    localparam int BIT_S1_DONE = 0;

    // irq status bit positions
    localparam int IRQ_S1_DONE = 0;
    localparam int IRQ_S1_COLL = 1;
    localparam int IRQ_S2_DONE = 2;
    localparam int IRQ_S2_COLL = 3;
    localparam int IRQ_CHANGE  = 4;
    localparam int IRQ_N       = 5;

    // mask of writable bits in the serial flag register (sticky ones only)
    localparam logic [7:0] STICKY_MASK = 8'h0F;
    localparam logic [7:0] RESET_BYTE  = 8'h00;

    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    wdata;
    } reg_req_t;

    // live state from the serial ports
    typedef struct packed {
        logic u1_rx_nonempty;
        logic u1_tx_room;
        logic u1_tx_shift_empty;
        logic u2_rx_nonempty;
        logic u2_tx_room;
        logic u2_tx_shift_empty;
        logic s1_collision;
        logic s1_done;
        logic s2_collision;
        logic s2_done;
    } serial_events_t;

endpackage : serial_flags_pkg

// ===== core/pin_edge_detect.sv
// pin-change edge detector: synchroniser, previous sample, enable gating
// assumes pins may change at any time; two flops precede the compare
module pin_edge_detect
    import serial_flags_pkg::*;
#(
    parameter int N = 6
) (
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire logic [N-1:0] PIN,
    input  wire logic [N-1:0] RISE_EN,
    input  wire logic [N-1:0] FALL_EN,
    output logic      [N-1:0] EDGE_HIT
);
    typedef struct packed {
        logic [N-1:0] sync1;
        logic [N-1:0] sync2;
        logic [N-1:0] prev;
    } edge_state_t;

    edge_state_t state;
    edge_state_t next_state;

    // refuse widths the enable registers cannot hold, at elaboration
    if (N < 1 || N > 8) begin : g_bad_n
        $error("pin_edge_detect: N out of range");
    end

    // first flop feeds only the second; prev holds the older clean sample
    always_comb begin
        next_state       = state;
        next_state.sync1 = PIN;
        next_state.sync2 = state.sync1;
        next_state.prev  = state.sync2;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // a disabled direction produces nothing
    assign EDGE_HIT = (RISE_EN & state.sync2 & ~state.prev)
                    | (FALL_EN & ~state.sync2 & state.prev);
endmodule : pin_edge_detect

// ===== core/sticky_flags.sv
// bank of sticky flags: hardware set wins over software clear
// assumes set and clear are one-cycle qualified pulses from the owner
module sticky_flags #(
    parameter int N = 5
) (
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire logic [N-1:0] SET,
    input  wire logic [N-1:0] CLR,
    output logic      [N-1:0] FLAGS
);
    typedef struct packed {
        logic [N-1:0] flags;
    } sticky_state_t;

    sticky_state_t state;
    sticky_state_t next_state;

    // an empty bank has no meaning; stop at elaboration
    if (N < 1) begin : g_bad_n
        $error("sticky_flags: N must be positive");
    end

    // set beats clear so an event on the clear cycle is kept
    always_comb begin
        next_state       = state;
        next_state.flags = (state.flags & ~CLR) | SET;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign FLAGS = state.flags;
endmodule : sticky_flags

// ===== core/serial_flags_and_pin_change_irq.sv
// serial interrupt flags, pin-change detection and a masked interrupt output
// assumes the serial ports present their live state on synchronous inputs
// Function
// - receive-ready flags, bits 7 and 5, read-only, high while buffer holds data
// - transmit-room flags, bits 6 and 4, read-only, high while buffer not full
// - room flag does not mean done; separate shift-empty status reports completion
// - collision flags, bits 3 and 1, set by hardware, held until software clears
// - done flags, bits 2 and 0, zero while busy, set on completion, software clears
// - serial flags set on their condition regardless of any enable bit
// - enabled rising edge on a pin sets its change flag and summary flag
// - enabled falling edge on a pin sets its change flag and summary flag
// - disabled edge direction sets no change flag
// - edge enable bits 7 and 6 read zero; enable bits reset to zero
module serial_flags_and_pin_change_irq
    import serial_flags_pkg::*;
#(
    parameter int PINS = PIN_N
) (
    input  wire logic                               CLK,
    input  wire logic                               RST,
    input  wire logic [serial_flags_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [serial_flags_pkg::DATA_W-1:0] WDATA,
    input  wire logic                               WR,
    input  wire logic                               RD,
    output logic      [serial_flags_pkg::DATA_W-1:0] RDATA,
    input  wire serial_flags_pkg::serial_events_t   SERIAL_EV,
    input  wire logic [PINS-1:0]                    PORTA_PIN,
    output logic                                    SYNC1_DONE_CLEARED,
    output logic                                    SYNC2_DONE_CLEARED,
    output logic                                    IRQ
);
    import serial_flags_pkg::*;

    typedef struct packed {
        logic [3:0]        sticky;    // sync2 coll, sync2 done, sync1 coll, sync1 done
        logic [PINS-1:0]   rise_en;
        logic [PINS-1:0]   fall_en;
        logic [PINS-1:0]   pin_flags;
        logic              summary;
        logic [IRQ_N-1:0]  irq_en;
        logic [DATA_W-1:0] rdata;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;

    reg_req_t         req;
    logic [PINS-1:0]  edge_hit;
    logic [IRQ_N-1:0] irq_set;
    logic [IRQ_N-1:0] irq_clr;
    logic [IRQ_N-1:0] irq_status;
    logic [3:0]       sticky_set;
    logic [3:0]       sticky_clr;
    logic [PINS-1:0]  pin_clr;
    logic [DATA_W-1:0] serial_view;

    // pin fields share one register byte, so wider ports are refused
    if (PINS < 1 || PINS > DATA_W) begin : g_bad_pins
        $error("PINS must fit one register");
    end

    // widen a pin-wide field into a register byte, upper bits read zero
    function automatic logic [DATA_W-1:0] pad_pins(input logic [PINS-1:0] v);
        logic [DATA_W-1:0] r;
        r = '0;
        r[PINS-1:0] = v;
        return r;
    endfunction : pad_pins

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
        return a == off;
    endfunction : hit

    assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

    pin_edge_detect #(
        .N (PINS)
    ) u_edges (
        .CLK      (CLK),
        .RST      (RST),
        .PIN      (PORTA_PIN),
        .RISE_EN  (state.rise_en),
        .FALL_EN  (state.fall_en),
        .EDGE_HIT (edge_hit)
    );

    // hardware events for the sticky serial bits, ungated by any enable
    always_comb begin
        sticky_set = 4'h0;
        sticky_set[BIT_S1_DONE] = SERIAL_EV.s1_done;
        sticky_set[BIT_S1_COLL] = SERIAL_EV.s1_collision;
        sticky_set[BIT_S2_DONE] = SERIAL_EV.s2_done;
        sticky_set[BIT_S2_COLL] = SERIAL_EV.s2_collision;
    end

    // software clears a sticky serial bit by writing zero to it
    assign sticky_clr = (req.wr && hit(req.addr, OFF_SERIAL_FLAGS))
                      ? ~req.wdata[3:0] : 4'h0;

    // pin flags clear by writing one, like the status clear register
    assign pin_clr = (req.wr && hit(req.addr, OFF_PIN_FLAGS))
                   ? req.wdata[PINS-1:0] : '0;

    // the room and ready bits are live views; a write cannot touch them
    always_comb begin
        serial_view = RESET_BYTE;
        serial_view[BIT_U2_RX] = SERIAL_EV.u2_rx_nonempty;
        serial_view[BIT_U2_TX] = SERIAL_EV.u2_tx_room;
        serial_view[BIT_U1_RX] = SERIAL_EV.u1_rx_nonempty;
        serial_view[BIT_U1_TX] = SERIAL_EV.u1_tx_room;
        serial_view[3:0]       = state.sticky & STICKY_MASK[3:0];
    end

    // interrupt events: completion, collision and any enabled pin edge
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_S1_DONE] = SERIAL_EV.s1_done;
        irq_set[IRQ_S1_COLL] = SERIAL_EV.s1_collision;
        irq_set[IRQ_S2_DONE] = SERIAL_EV.s2_done;
        irq_set[IRQ_S2_COLL] = SERIAL_EV.s2_collision;
        irq_set[IRQ_CHANGE]  = |edge_hit;
    end

    assign irq_clr = (req.wr && hit(req.addr, OFF_IRQ_CLEAR)) ? req.wdata[IRQ_N-1:0] : '0;

    sticky_flags #(
        .N (IRQ_N)
    ) u_irq_status (
        .CLK   (CLK),
        .RST   (RST),
        .SET   (irq_set),
        .CLR   (irq_clr),
        .FLAGS (irq_status)
    );

    // register writes, sticky updates and read capture
    always_comb begin
        next_state = state;
        // set wins over a clear in the same cycle
        next_state.sticky    = (state.sticky & ~sticky_clr) | sticky_set;
        next_state.pin_flags = (state.pin_flags & ~pin_clr) | edge_hit;
        // summary follows any pin flag; it drops once all pin flags are clear
        next_state.summary   = |next_state.pin_flags;
        if (req.wr) begin
            unique case (req.addr)
                OFF_RISE_EN:    next_state.rise_en = req.wdata[PINS-1:0];
                OFF_FALL_EN:    next_state.fall_en = req.wdata[PINS-1:0];
                OFF_IRQ_ENABLE: next_state.irq_en  = req.wdata[IRQ_N-1:0];
                default: ;
            endcase
        end
        next_state.rdata = RESET_BYTE;
        if (req.rd) begin
            unique case (req.addr)
                OFF_SERIAL_FLAGS: next_state.rdata = serial_view;
                OFF_RISE_EN:      next_state.rdata = pad_pins(state.rise_en);
                OFF_FALL_EN:      next_state.rdata = pad_pins(state.fall_en);
                OFF_PIN_FLAGS:    next_state.rdata = pad_pins(state.pin_flags);
                OFF_IRQ_STATUS: begin
                    next_state.rdata = RESET_BYTE;
                    next_state.rdata[IRQ_N-1:0] = irq_status;
                end
                OFF_IRQ_ENABLE: begin
                    next_state.rdata = RESET_BYTE;
                    next_state.rdata[IRQ_N-1:0] = state.irq_en;
                end
                OFF_TX_STATUS: begin
                    // shift-empty is the completion indication, not the room flag
                    next_state.rdata    = RESET_BYTE;
                    next_state.rdata[0] = SERIAL_EV.u1_tx_shift_empty;
                    next_state.rdata[1] = SERIAL_EV.u2_tx_shift_empty;
                    next_state.rdata[2] = state.summary;
                end
                default:          next_state.rdata = RESET_BYTE; // unmapped reads zero
            endcase
        end
    end

    // all enables and flags come up cleared
    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign RDATA = state.rdata;
    // lets a port know software acknowledged completion; it may start its next job
    assign SYNC1_DONE_CLEARED = sticky_clr[BIT_S1_DONE] & state.sticky[BIT_S1_DONE];
    assign SYNC2_DONE_CLEARED = sticky_clr[BIT_S2_DONE] & state.sticky[BIT_S2_DONE];
    // only enabled status reaches the pin; clearing flags first avoids a stale hit
    assign IRQ = |(irq_status & state.irq_en);
endmodule : serial_flags_and_pin_change_irq

// ===== bench/serial_flags_and_pin_change_irq_chk.sv
// port checker for the serial flag and pin-change block
// assumes it is bound to the top module and sees only its ports
module serial_flags_and_pin_change_irq_chk
    import serial_flags_pkg::*;
#(
    parameter int PINS = PIN_N
) (
    input wire logic                  CLK,
    input wire logic                  RST,
    input wire logic [ADDR_W-1:0]     ADDR,
    input wire logic [DATA_W-1:0]     WDATA,
    input wire logic                  WR,
    input wire logic                  RD,
    input wire logic [DATA_W-1:0]     RDATA,
    input wire serial_events_t        SERIAL_EV,
    input wire logic [PINS-1:0]       PORTA_PIN,
    input wire logic                  SYNC1_DONE_CLEARED,
    input wire logic                  SYNC2_DONE_CLEARED,
    input wire logic                  IRQ
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);

    // read of the serial flag register; data land one cycle later
    sequence rd_flags;
        RD && ADDR == OFF_SERIAL_FLAGS;
    endsequence

    // live bits show the port levels of the read cycle
    AST_RX_LIVE: assert property (rd_flags |=>
        RDATA[BIT_U2_RX] == $past(SERIAL_EV.u2_rx_nonempty)
        && RDATA[BIT_U1_RX] == $past(SERIAL_EV.u1_rx_nonempty)) else $error("rx ready bit wrong");
    AST_TX_LIVE: assert property (rd_flags |=>
        RDATA[BIT_U2_TX] == $past(SERIAL_EV.u2_tx_room)
        && RDATA[BIT_U1_TX] == $past(SERIAL_EV.u1_tx_room)) else $error("tx room bit wrong");
    AST_EN_TOP: assert property (RD && (ADDR == OFF_RISE_EN || ADDR == OFF_FALL_EN)
        |=> RDATA[7:6] == 2'b00) else $error("enable top bits not zero");
    // an event is visible to a read issued right after it, whatever the enables
    AST_COLL_SET: assert property (SERIAL_EV.s2_collision ##1 rd_flags
        |=> RDATA[BIT_S2_COLL]) else $error("collision flag not set");
    AST_DONE_SET: assert property (SERIAL_EV.s1_done ##1 rd_flags
        |=> RDATA[BIT_S1_DONE]) else $error("done flag not set");
    AST_STICKY: assert property (rd_flags ##1 (RDATA[BIT_S2_COLL] && !WR)
        ##1 rd_flags |=> RDATA[BIT_S2_COLL]) else $error("collision flag lost");
    AST_DONE_CLR: assert property (SYNC1_DONE_CLEARED
        |-> WR && ADDR == OFF_SERIAL_FLAGS && !WDATA[BIT_S1_DONE]) else $error("stray clear pulse");
    AST_IRQ_MASK: assert property (WR && ADDR == OFF_IRQ_ENABLE && WDATA == 8'h00
        |=> !IRQ) else $error("irq high with all enables off");

    // main scenarios reached
    COV_EVENT: cover property (SERIAL_EV.s2_collision ##1 rd_flags);
    COV_CLEAR: cover property (SYNC1_DONE_CLEARED);
    COV_IRQ: cover property ($rose(IRQ));
endmodule : serial_flags_and_pin_change_irq_chk

bind serial_flags_and_pin_change_irq serial_flags_and_pin_change_irq_chk #(.PINS(PINS)) chk_i (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SERIAL_EV(SERIAL_EV), .PORTA_PIN(PORTA_PIN), .SYNC1_DONE_CLEARED(SYNC1_DONE_CLEARED),
    .SYNC2_DONE_CLEARED(SYNC2_DONE_CLEARED), .IRQ(IRQ));

// ===== bench/tb_serial_flags_and_pin_change_irq.sv
// register-level testbench for the serial flag and pin-change block
// assumes one 100 MHz clock and the one-cycle read latency of the register port
module tb_serial_flags_and_pin_change_irq;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_flags_pkg::*;

    logic           CLK = 1'b0;
    logic           RST = 1'b1;
    logic [3:0]     ADDR;
    logic [7:0]     WDATA;
    logic           WR;
    logic           RD;
    logic [7:0]     RDATA;
    serial_events_t SERIAL_EV;
    logic [5:0]     PORTA_PIN;
    logic           SYNC1_DONE_CLEARED;
    logic           SYNC2_DONE_CLEARED;
    logic           IRQ;
    logic [1:0]     clr_seen;
    int             err_count = 0;
    int             compares = 0;

    serial_flags_and_pin_change_irq dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .SERIAL_EV(SERIAL_EV), .PORTA_PIN(PORTA_PIN),
        .SYNC1_DONE_CLEARED(SYNC1_DONE_CLEARED), .SYNC2_DONE_CLEARED(SYNC2_DONE_CLEARED),
        .IRQ(IRQ));

    // free-running clock
    always #5 CLK = ~CLK;

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // the clear pulse is combinational, so it is caught inside the write cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        #1 clr_seen = {SYNC2_DONE_CLEARED, SYNC1_DONE_CLEARED};
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk($sformatf("reg%0h", a), RDATA, e);
    endtask : rd

    // one-cycle event pulse followed at once by a flag read
    task automatic evrd(input logic [9:0] v, input logic [7:0] e);
        @(posedge CLK);
        SERIAL_EV <= SERIAL_EV | v;
        @(posedge CLK);
        SERIAL_EV <= SERIAL_EV & ~v;
        ADDR <= OFF_SERIAL_FLAGS;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk("flags", RDATA, e);
    endtask : evrd

    // pin change, then enough cycles for synchroniser and compare
    task automatic pins(input logic [5:0] v);
        @(posedge CLK);
        PORTA_PIN <= v;
        repeat (5) @(posedge CLK);
    endtask : pins

    task automatic complete_run;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // hang guard
    initial begin
        #200000;
        err_count++;
        complete_run();
    end

    // main sequence
    initial begin
        ADDR = 4'h0;
        WDATA = 8'h00;
        WR = 1'b0;
        RD = 1'b0;
        SERIAL_EV = '0;
        PORTA_PIN = 6'h00;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        for (int a = 0; a < 9; a++) rd(4'(a), 8'h00);
        wr(OFF_RISE_EN, 8'hFF);
        rd(OFF_RISE_EN, 8'h3F);
        wr(OFF_FALL_EN, 8'hFF);
        rd(OFF_FALL_EN, 8'h3F);
        wr(OFF_FALL_EN, 8'h00);
        SERIAL_EV <= 10'h1C0;
        wr(OFF_SERIAL_FLAGS, 8'hFF);
        rd(OFF_SERIAL_FLAGS, 8'h90);
        // uart1 room drops here; the bench never writes transmit data into a full buffer
        @(posedge CLK) SERIAL_EV <= 10'h2A0;
        rd(OFF_SERIAL_FLAGS, 8'h60);
        rd(OFF_TX_STATUS, 8'h01);
        evrd(10'h006, 8'h69);
        rd(OFF_SERIAL_FLAGS, 8'h69);
        chk("irq", {7'h00, IRQ}, 8'h00);
        rd(OFF_IRQ_STATUS, 8'h09);
        wr(OFF_IRQ_ENABLE, 8'h1F);
        // irq is looked at after the edge that registers the enable has settled
        #1 chk("irq", {7'h00, IRQ}, 8'h01);
        wr(OFF_SERIAL_FLAGS, 8'h0E);
        chk("clr", {6'h00, clr_seen}, 8'h01);
        wr(OFF_SERIAL_FLAGS, 8'h06);
        rd(OFF_SERIAL_FLAGS, 8'h60);
        // the other collision and done bits, and the second clear pulse
        evrd(10'h009, 8'h66);
        rd(OFF_IRQ_STATUS, 8'h0F);
        wr(OFF_SERIAL_FLAGS, 8'h0B);
        chk("clr", {6'h00, clr_seen}, 8'h02);
        wr(OFF_SERIAL_FLAGS, 8'h0D);
        rd(OFF_SERIAL_FLAGS, 8'h60);
        wr(OFF_IRQ_CLEAR, 8'h1F);
        rd(OFF_IRQ_STATUS, 8'h00);
        chk("irq", {7'h00, IRQ}, 8'h00);
        pins(6'h01);
        rd(OFF_PIN_FLAGS, 8'h01);
        rd(OFF_TX_STATUS, 8'h05);
        chk("irq", {7'h00, IRQ}, 8'h01);
        wr(OFF_PIN_FLAGS, 8'h01);
        wr(OFF_IRQ_CLEAR, 8'h1F);
        wr(OFF_RISE_EN, 8'h00);
        pins(6'h3E);
        rd(OFF_PIN_FLAGS, 8'h00);
        wr(OFF_FALL_EN, 8'h3F);
        pins(6'h00);
        rd(OFF_PIN_FLAGS, 8'h3E);
        wr(OFF_IRQ_ENABLE, 8'h00);
        #1 chk("irq", {7'h00, IRQ}, 8'h00);
        // second reset in mid-run
        @(posedge CLK);
        RST <= 1'b1;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        rd(OFF_FALL_EN, 8'h00);
        rd(OFF_PIN_FLAGS, 8'h00);
        complete_run();
    end
endmodule : tb_serial_flags_and_pin_change_irq
